// ==== src/prs_rx_lane_status.sv ====
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - report physical lane for pcs lanes 2, 3
// - lane map taken from good markers on block-locked lanes; held after marker lock drops
// - one-cycle pulse on bad lane parity
// - synced level: word lock and marker seen
// - sync error level: lock lost or no marker
// - pulse when marker spacing mismatches interval
// - pulse after four marker errors in row
// - pulse on malformed lane marker word
// - provide remote loopback and test pattern
// - test pattern is scrambled continuous idles
module prs_rx_lane_status (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire prs_pkg::prs_lane_in_type lane_in,
  input wire logic [prs_pkg::LOOPBACK_W-1:0] transceiver_loopback_select,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic [1:0] lane2_physical_map,
  output logic [1:0] lane3_physical_map,
  output logic [prs_pkg::LANES-1:0] lane_marker_lock,
  output logic [prs_pkg::LANES-1:0] bip_error,
  output logic [prs_pkg::LANES-1:0] lane_synced,
  output logic [prs_pkg::LANES-1:0] lane_sync_error,
  output logic [prs_pkg::LANES-1:0] marker_spacing_error,
  output logic [prs_pkg::LANES-1:0] marker_repeat_error,
  output logic marker_format_error,
  output logic remote_loopback_en,
  output logic tx_word_valid,
  output logic [1:0] tx_header,
  output logic [63:0] tx_payload
);

  localparam int N = prs_pkg::LANES;
  localparam int IW = prs_pkg::INTERVAL_W;

  // ************************************************************
  // input synchronisers and link edge detection
  // ************************************************************
  prs_pkg::prs_lane_in_type in_s1_reg, in_s2_reg;
  logic clk_s1_reg, clk_s2_reg, clk_q_reg;
  logic [prs_pkg::LOOPBACK_W-1:0] lb_s1_reg, lb_s2_reg;
  logic link_rise;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      in_s1_reg <= '0;
      in_s2_reg <= '0;
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_q_reg <= 1'b0;
      lb_s1_reg <= '0;
      lb_s2_reg <= '0;
    end else begin
      in_s1_reg <= lane_in;
      in_s2_reg <= in_s1_reg;
      clk_s1_reg <= link_clk;
      clk_s2_reg <= clk_s1_reg;
      clk_q_reg <= clk_s2_reg;
      lb_s1_reg <= transceiver_loopback_select;
      lb_s2_reg <= lb_s1_reg;
    end
  end

  assign link_rise = clk_s2_reg & ~clk_q_reg;

  // ************************************************************
  // control and interrupt registers
  // ************************************************************
  logic [IW-1:0] interval_reg;
  logic test_en_reg;
  logic [prs_pkg::EV_W-1:0] ev_reg, mask_reg, ev_set, ev_clr;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      interval_reg <= prs_pkg::INTERVAL_RESET;
      test_en_reg <= 1'b0;
      remote_loopback_en <= 1'b0;
      mask_reg <= '0;
    end else if (reg_wr && reg_addr == prs_pkg::ADDR_CTRL) begin
      interval_reg <= reg_wdata[IW-1:0];
      test_en_reg <= reg_wdata[prs_pkg::CTRL_TEST_BIT];
      remote_loopback_en <= reg_wdata[prs_pkg::CTRL_RLOOP_BIT];
    end else if (reg_wr && reg_addr == prs_pkg::ADDR_MASK) begin
      mask_reg <= reg_wdata[prs_pkg::EV_W-1:0];
    end
  end

  assign ev_set = {marker_format_error, marker_repeat_error, marker_spacing_error, bip_error};
  assign ev_clr = (reg_wr && reg_addr == prs_pkg::ADDR_EVENT) ? reg_wdata[prs_pkg::EV_W-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ev_reg <= '0;
      irq <= 1'b0;
    end else begin
      ev_reg <= (ev_reg & ~ev_clr) | ev_set;
      irq <= |(((ev_reg & ~ev_clr) | ev_set) & mask_reg);
    end
  end

  // ************************************************************
  // register read port
  // ************************************************************
  logic [31:0] status_word;

  assign status_word = {10'h000, lb_s2_reg, lane3_physical_map, lane2_physical_map,
                        lane_marker_lock, lane_sync_error, lane_synced};

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == prs_pkg::ADDR_CTRL) begin
      reg_rdata <= {14'h0000, remote_loopback_en, test_en_reg, interval_reg};
    end else if (reg_addr == prs_pkg::ADDR_STATUS) begin
      reg_rdata <= status_word;
    end else if (reg_addr == prs_pkg::ADDR_EVENT) begin
      reg_rdata <= {19'h00000, ev_reg};
    end else if (reg_addr == prs_pkg::ADDR_MASK) begin
      reg_rdata <= {19'h00000, mask_reg};
    end else begin
      reg_rdata <= '0;
    end
  end

  // ************************************************************
  // per-lane marker tracking
  // ************************************************************
  logic [N-1:0] blk_lock_reg, seen_reg, lost_reg;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lane
      logic [IW-1:0] cnt_reg;
      logic [2:0] err_run_reg;
      logic mk, mk_bad, spacing_bad, mk_err;

      assign mk = link_rise & in_s2_reg.marker[g];
      assign mk_bad = mk & in_s2_reg.marker_bad[g];
      assign spacing_bad = mk & seen_reg[g] & (cnt_reg != interval_reg);
      assign mk_err = mk_bad | spacing_bad;

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          cnt_reg <= '0;
        end else if (mk || !blk_lock_reg[g]) begin
          cnt_reg <= '0;
        end else if (link_rise) begin
          cnt_reg <= cnt_reg + IW'(1);
        end
      end

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          err_run_reg <= '0;
          marker_spacing_error[g] <= 1'b0;
          marker_repeat_error[g] <= 1'b0;
          bip_error[g] <= 1'b0;
        end else begin
          marker_spacing_error[g] <= spacing_bad;
          bip_error[g] <= link_rise & in_s2_reg.bip_bad[g];
          marker_repeat_error[g] <= mk_err && (err_run_reg == prs_pkg::REPEAT_LIMIT - 3'h1);
          if (mk_err && err_run_reg == prs_pkg::REPEAT_LIMIT - 3'h1) begin
            err_run_reg <= '0;
          end else if (mk_err) begin
            err_run_reg <= err_run_reg + 3'h1;
          end else if (mk) begin
            err_run_reg <= '0;
          end
        end
      end

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          blk_lock_reg[g] <= 1'b0;
          seen_reg[g] <= 1'b0;
          lost_reg[g] <= 1'b0;
          lane_marker_lock[g] <= 1'b0;
        end else if (link_rise) begin
          blk_lock_reg[g] <= in_s2_reg.block_lock[g];
          if (!in_s2_reg.block_lock[g]) begin
            seen_reg[g] <= 1'b0;
            lane_marker_lock[g] <= 1'b0;
            lost_reg[g] <= lost_reg[g] | blk_lock_reg[g];
          end else if (mk && !mk_bad) begin
            seen_reg[g] <= 1'b1;
            lost_reg[g] <= 1'b0;
            lane_marker_lock[g] <= 1'b1;
          end else if (marker_repeat_error[g]) begin
            lane_marker_lock[g] <= 1'b0;
          end
        end else if (marker_repeat_error[g]) begin
          lane_marker_lock[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ************************************************************
  // level status and format error
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lane_synced <= '0;
      lane_sync_error <= '0;
      marker_format_error <= 1'b0;
    end else begin
      lane_synced <= blk_lock_reg & seen_reg;
      lane_sync_error <= lost_reg | (blk_lock_reg & ~seen_reg);
      marker_format_error <= link_rise & |(in_s2_reg.marker & in_s2_reg.marker_bad);
    end
  end

  // ************************************************************
  // lane map
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lane2_physical_map <= 2'h0;
      lane3_physical_map <= 2'h0;
    end else if (link_rise) begin
      for (int p = 0; p < N; p++) begin
        if (in_s2_reg.marker[p] && !in_s2_reg.marker_bad[p] && in_s2_reg.block_lock[p]) begin
          if (in_s2_reg.marker_id[2*p +: 2] == 2'h2) begin
            lane2_physical_map <= p[1:0];
          end
          if (in_s2_reg.marker_id[2*p +: 2] == 2'h3) begin
            lane3_physical_map <= p[1:0];
          end
        end
      end
    end
  end

  // ************************************************************
  // transmit test pattern
  // ************************************************************
  logic [prs_pkg::SCR_W-1:0] scr_reg;

  function automatic logic [prs_pkg::SCR_W+63:0] prs_scramble(input logic [prs_pkg::SCR_W-1:0] s_in,
                                                              input logic [63:0] d);
    logic [prs_pkg::SCR_W-1:0] s;
    logic [63:0] o;
    s = s_in;
    o = '0;
    for (int i = 0; i < 64; i++) begin
      o[i] = d[i] ^ s[prs_pkg::SCR_TAP_A] ^ s[prs_pkg::SCR_TAP_B];
      s = {s[prs_pkg::SCR_W-2:0], o[i]};
    end
    return {s, o};
  endfunction : prs_scramble

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scr_reg <= '1;
      tx_word_valid <= 1'b0;
      tx_header <= 2'h0;
      tx_payload <= '0;
    end else begin
      tx_word_valid <= link_rise & test_en_reg;
      if (link_rise && test_en_reg) begin
        {scr_reg, tx_payload} <= prs_scramble(scr_reg, prs_pkg::IDLE_BLOCK);
        tx_header <= prs_pkg::HDR_CONTROL;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_bad_marker;
    link_rise && (in_s2_reg.marker & in_s2_reg.marker_bad) != '0;
  endsequence

  sequence s_bip_seen;
    link_rise && in_s2_reg.bip_bad[0];
  endsequence

  a_bip_pulse_one: assert property (bip_error[0] |=> !bip_error[0])
    else $error("bip pulse longer than one cycle");
  a_bip_from_cause: assert property (s_bip_seen |=> bip_error[0])
    else $error("bip error not reported");
  a_spacing_cause: assert property (marker_spacing_error[0] |-> $past(link_rise && in_s2_reg.marker[0]))
    else $error("spacing error without marker");
  a_repeat_pulse_one: assert property (marker_repeat_error != '0 |=>
      (marker_repeat_error & $past(marker_repeat_error)) == '0 &&
      (lane_marker_lock & $past(marker_repeat_error)) == '0)
    else $error("repeat error not single or lock kept");
  a_format_flag: assert property (s_bad_marker |=> marker_format_error ##1 !marker_format_error)
    else $error("format error pulse wrong");
  a_synced_lock: assert property (lane_synced[0] |-> $past(blk_lock_reg[0]) && !lane_sync_error[0])
    else $error("synced without word lock");
  a_sync_err_excl: assert property (lane_sync_error[0] |-> !lane_synced[0])
    else $error("sync error and synced together");
  a_map_update: assert property ($changed(lane2_physical_map) |-> $past(link_rise))
    else $error("lane map moved outside a link word");
  a_test_idle: assert property (link_rise && test_en_reg |=> tx_word_valid && tx_header == 2'h2)
    else $error("test pattern word missing");

endmodule : prs_rx_lane_status

// ==== src/prs_pkg.sv ====
package prs_pkg;

  // ************************************************************
  // widths and lane count
  // ************************************************************
  localparam int LANES = 4;
  localparam int INTERVAL_W = 16;
  localparam int LOOPBACK_W = 6;
  localparam int SCR_W = 58;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EVENT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int CTRL_TEST_BIT = 16;
  localparam int CTRL_RLOOP_BIT = 17;
  localparam logic [15:0] INTERVAL_RESET = 16'h3fff;
  localparam int ST_SYNCED_LSB = 0;
  localparam int ST_SYNC_ERR_LSB = 4;
  localparam int ST_LOCK_LSB = 8;
  localparam int ST_MAP2_LSB = 12;
  localparam int ST_MAP3_LSB = 14;
  localparam int ST_LOOPBACK_LSB = 16;
  localparam int EV_BIP_LSB = 0;
  localparam int EV_SPACING_LSB = 4;
  localparam int EV_REPEAT_LSB = 8;
  localparam int EV_FORMAT_BIT = 12;
  localparam int EV_W = 13;
  localparam logic [2:0] REPEAT_LIMIT = 3'h4;

  // ************************************************************
  // transmit test pattern
  // ************************************************************
  localparam logic [1:0] HDR_CONTROL = 2'h2;
  localparam logic [63:0] IDLE_BLOCK = 64'h0000_0000_0000_001e;
  localparam int SCR_TAP_A = 38;
  localparam int SCR_TAP_B = 57;

  // per-word lane indications from the receive lanes
  typedef struct packed {
    logic [LANES-1:0] block_lock;
    logic [LANES-1:0] marker;
    logic [LANES-1:0] marker_bad;
    logic [LANES-1:0] bip_bad;
    logic [2*LANES-1:0] marker_id;
  } prs_lane_in_type;

endpackage : prs_pkg

// ==== tb/prs_link_model.sv ====
`timescale 1ns/1ps
// ************************************************************
// far-end transmitter: one lane word per link clock period
// ************************************************************
module prs_link_model (
  output logic link_clk,
  output prs_pkg::prs_lane_in_type lane_in
);
  initial begin
    link_clk = 1'b0;
    lane_in = '0;
  end

  // link clock stands low between frames; fields turn over once hold time is spent
  task automatic send(input logic [3:0] lk, input logic [3:0] mk, input logic [3:0] bad,
                      input logic [3:0] bip, input logic [7:0] id);
    #3;
    lane_in = '{lk, mk, bad, bip, id};
    #80 link_clk = 1'b1;
    #40;
    lane_in.marker = ~mk;
    lane_in.marker_bad = ~bad;
    lane_in.bip_bad = ~bip;
    lane_in.marker_id = ~id;
    #37 link_clk = 1'b0;
  endtask : send
endmodule : prs_link_model

// ==== tb/prs_rx_lane_status_test.sv ====
`timescale 1ns/1ps
module prs_rx_lane_status_test;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic link_clk;
  prs_pkg::prs_lane_in_type lane_in;
  logic [prs_pkg::LOOPBACK_W-1:0] sel = 6'h2a;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, v;
  logic irq, rloop, txv, fmt;
  logic [1:0] map2, map3, txh;
  logic [63:0] txp;
  logic [3:0] lock, bip, syn, serr, spc, rep, lk;
  logic [3:0] acc [4];
  int hi [4];
  int bad_count = 0;
  int n_checks = 0;
  int i;

  always #4 ref_clk = ~ref_clk;

  prs_link_model lm_u (.link_clk(link_clk), .lane_in(lane_in));

  prs_rx_lane_status dut_u (.ref_clk(ref_clk), .rstn(rstn), .link_clk(link_clk), .lane_in(lane_in),
    .transceiver_loopback_select(sel), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .irq(irq), .lane2_physical_map(map2), .lane3_physical_map(map3),
    .lane_marker_lock(lock), .bip_error(bip), .lane_synced(syn), .lane_sync_error(serr),
    .marker_spacing_error(spc), .marker_repeat_error(rep), .marker_format_error(fmt),
    .remote_loopback_en(rloop), .tx_word_valid(txv), .tx_header(txh), .tx_payload(txp));

  // ************************************************************
  // pulse capture: which bits rose and for how many cycles
  // ************************************************************
  always @(negedge ref_clk) begin
    acc[0] |= bip;
    acc[1] |= spc;
    acc[2] |= rep;
    acc[3] |= {3'h0, fmt};
    hi[0] += (bip !== 4'h0);
    hi[1] += (spc !== 4'h0);
    hi[2] += (rep !== 4'h0);
    hi[3] += (fmt !== 1'b0);
  end

  task automatic clr();
    #1;
    for (int k = 0; k < 4; k++) begin
      acc[k] = 4'h0;
      hi[k] = 0;
    end
  endtask : clr

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  task automatic wd(input int n, input logic [3:0] mk, input logic [3:0] bd, input logic [3:0] bp);
    repeat (n) lm_u.send(lk, mk, bd, bp, 8'hb1);
  endtask : wd

  function automatic logic [63:0] scr_idle();
    logic [57:0] s;
    logic o;
    logic [63:0] r;
    s = '1;
    for (int k = 0; k < 64; k++) begin
      o = prs_pkg::IDLE_BLOCK[k] ^ s[prs_pkg::SCR_TAP_A] ^ s[prs_pkg::SCR_TAP_B];
      s = {s[56:0], o};
      r[k] = o;
    end
    return r;
  endfunction : scr_idle

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  initial begin
    #200000;
    bad_count++;
    end_sim();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    lk = 4'hf;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    rreg(prs_pkg::ADDR_CTRL, v); chk("ctrl reset", 32'h0000_3fff, v);
    rreg(8'h10, v); chk("unmapped read", 32'h0, v);
    wreg(8'h10, 32'hffff_ffff); rreg(prs_pkg::ADDR_CTRL, v); chk("ctrl kept", 32'h0000_3fff, v);
    rreg(prs_pkg::ADDR_STATUS, v); chk("status", 32'h002a_0000, v);
    wreg(prs_pkg::ADDR_CTRL, 32'h0000_0003);
    wd(1, 4'h0, 4'h0, 4'h0);
    chk("synced no marker", 4'h0, syn);
    chk("sync err no marker", 4'hf, serr);
    wd(1, 4'hf, 4'h0, 4'h0);
    chk("synced", 4'hf, syn);
    chk("sync err", 4'h0, serr);
    chk("marker lock", 4'hf, lock);
    chk("map2", 2'h3, map2);
    chk("map3", 2'h2, map3);
    wd(3, 4'h0, 4'h0, 4'h0);
    clr();
    wd(1, 4'hf, 4'h0, 4'h0);
    chk("spacing ok", 4'h0, acc[1]);
    wd(1, 4'h0, 4'h0, 4'h0);
    clr();
    wd(1, 4'hf, 4'h0, 4'h1);
    chk("spacing err", {4'hf, 32'h1}, {acc[1], hi[1]});
    chk("bip err", {4'h1, 32'h1}, {acc[0], hi[0]});
    rreg(prs_pkg::ADDR_EVENT, v); chk("event", 32'h0000_00f1, v);
    chk("irq masked", 1'b0, irq);
    wreg(prs_pkg::ADDR_MASK, 32'h0000_0010); chk("irq", 1'b1, irq);
    wreg(prs_pkg::ADDR_EVENT, 32'h0000_1fff); chk("irq cleared", 1'b0, irq);
    rreg(prs_pkg::ADDR_EVENT, v); chk("event cleared", 32'h0, v);
    wd(3, 4'h0, 4'h0, 4'h0);
    wd(1, 4'hf, 4'h0, 4'h0);
    clr();
    repeat (4) begin
      wd(3, 4'h0, 4'h0, 4'h0);
      wd(1, 4'hf, 4'h2, 4'h0);
    end
    chk("format err", {4'h1, 32'h4}, {acc[3], hi[3]});
    chk("repeat err", {4'h2, 32'h1}, {acc[2], hi[2]});
    chk("lock after repeat", 4'hd, lock);
    lk = 4'h7;
    wd(1, 4'h0, 4'h0, 4'h0);
    chk("lock loss", 3'h2, {syn[3], serr[3], lock[3]});
    @(posedge ref_clk);
    sel <= 6'h15;
    // let the select pass both synchroniser stages before reading it back
    repeat (2) @(posedge ref_clk);
    rreg(prs_pkg::ADDR_STATUS, v); chk("loopback sel", 6'h15, v[21:16]);
    wreg(prs_pkg::ADDR_CTRL, 32'h0003_0003);
    chk("remote loop", 1'b1, rloop);
    fork
      wd(2, 4'h0, 4'h0, 4'h0);
    join_none
    i = 0;
    while (txv !== 1'b1 && i < 200) begin
      @(negedge ref_clk);
      i++;
    end
    chk("tx valid", 1'b1, txv);
    chk("tx header", prs_pkg::HDR_CONTROL, txh);
    chk("tx payload", scr_idle(), txp);
    wait fork;
    end_sim();
  end
endmodule : prs_rx_lane_status_test
